// [design/cpu_top.sv]
// Compare and PWM unit pair with event timer, PWM base timer and APB registers.
//
// Function
// - Compare value continuously matched against event timer.
// - Codes 1000/1001 drive pin high/low, set flag.
// - 1010 flag only, 1011 trigger, 11xx PWM.
// - Code 0000 turns unit off, resets state.
// - Zero control write forces compare latch low.
// - Flag-only compare leaves pin unchanged.
// - Unit A trigger resets event timer.
// - Unit B trigger resets timer, starts conversion.
// - Unit B timer reset sets no overflow flag.
// - PWM mode gives up to ten-bit output.
// - Zero control write forces PWM latch low.
// - Period match clears timer, latches duty byte.
// - Period match sets pin unless duty zero.
// - Postscaler plays no part in PWM period.
// - Duty is value byte then two low bits.
// - Duty writes anytime, effective after period match.
// - High duty register read-only in PWM mode.
// - Duty double-buffered with 2-bit internal latch.
// - Pin clears when buffered duty meets extended timer.
// - Duty beyond period never clears pin.
// - Base timer prescaler divides by 1, 4, 16.
// - Resolution equals log2 of clock over PWM rate at prescale 1.
`timescale 1ns/1ns
`default_nettype none
`include "cpu_cfg.svh"

module cpu_top (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [11:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic pready,
	output logic [31:0] prdata,
	output logic pslverr,
	input wire logic adc_enabled,
	output cpu_pkg::cpu_pin_type unit_a_pin,
	output cpu_pkg::cpu_pin_type unit_b_pin,
	output logic adc_start
);

	// ****************************************
	// State
	// ****************************************
	cpu_pkg::cpu_state_type s_r;
	cpu_pkg::cpu_state_type s_nxt;

	localparam logic [1:0][9:0] VLO_IDX = {`CPU_IDX_B_VLO, `CPU_IDX_A_VLO};
	localparam logic [1:0][9:0] VHI_IDX = {`CPU_IDX_B_VHI, `CPU_IDX_A_VHI};
	localparam logic [1:0][9:0] CTL_IDX = {`CPU_IDX_B_CTL, `CPU_IDX_A_CTL};

	logic [9:0] idx;
	logic [7:0] wd;
	logic setup;
	logic access;
	logic wr;
	logic icyc;
	logic [1:0] t1_ps;
	logic [2:0] t1_mask;
	logic t1tick;
	logic [1:0] t2_ps;
	logic [3:0] t2_mask;
	logic t2tick;
	logic pmatch;
	logic [1:0] low2;
	logic frac_step;
	logic [7:0] rd_val;
	logic rd_hit;

	// ****************************************
	// Bus decode
	// ****************************************
	assign idx = paddr[11:2];
	assign wd = pwdata[7:0];
	assign setup = psel && !penable;
	assign access = psel && penable;
	assign wr = access && pwrite;

	// Zero wait states: read data was sampled in the setup cycle
	assign pready = access;
	assign prdata = {24'h00_0000, s_r.rdata};
	assign pslverr = access && s_r.err;

	// ****************************************
	// Time bases
	// ****************************************
	// Instruction cycle is four core clocks, the q phase
	assign icyc = s_r.q == 2'b11;

	// Event timer prescale 1, 2, 4 or 8
	assign t1_ps = s_r.event_timer_control[`CPU_T1_PS_LSB +: 2];
	assign t1_mask = {&t1_ps, t1_ps[1], |t1_ps};
	assign t1tick = icyc && s_r.event_timer_control[`CPU_T1_ON] && ((s_r.t1pre & t1_mask) == t1_mask);

	// PWM base timer prescale 1, 4 or 16
	assign t2_ps = s_r.pwm_timer_control[`CPU_T2_PS_LSB +: 2];
	assign t2_mask = {t2_ps[1], t2_ps[1], |t2_ps, |t2_ps};
	assign t2tick = icyc && s_r.pwm_timer_control[`CPU_T2_ON] && ((s_r.pre2 & t2_mask) == t2_mask);

	// Period end is only timer versus limit; postscaler not involved
	assign pmatch = t2tick && (s_r.pwm_base_timer == s_r.pr2);

	// Fractional count steps on this clock; clearing on the step keeps high time at duty counts
	assign frac_step = s_r.pwm_timer_control[`CPU_T2_ON]
		&& ((t2_ps == 2'b00) || (icyc && (!t2_ps[1] || s_r.pre2[1:0] == 2'b11)));

	// Two fractional bits under the base timer: q phase or prescaler bits
	always_comb begin
		if (t2_ps == 2'b00) begin
			low2 = s_r.q;
		end else if (t2_ps[1]) begin
			low2 = s_r.pre2[3:2];
		end else begin
			low2 = s_r.pre2[1:0];
		end
	end

	// ****************************************
	// Register read
	// ****************************************
	always_comb begin
		rd_val = 8'h00;
		rd_hit = 1'b1;
		case (idx)
			`CPU_IDX_CORE_IRQ: begin
				rd_val = s_r.core_irq;
			end
			`CPU_IDX_FLAGS_ONE: begin
				rd_val = s_r.flags;
			end
			`CPU_IDX_FLAGS_B: begin
				rd_val = s_r.flags_b;
			end
			`CPU_IDX_TMR_LOW: begin
				rd_val = s_r.t1[7:0];
			end
			`CPU_IDX_TMR_HIGH: begin
				rd_val = s_r.t1[15:8];
			end
			`CPU_IDX_TMR_CTL: begin
				rd_val = s_r.event_timer_control;
			end
			`CPU_IDX_PWM_TMR: begin
				rd_val = s_r.pwm_base_timer;
			end
			`CPU_IDX_PWM_TCTL: begin
				rd_val = s_r.pwm_timer_control;
			end
			`CPU_IDX_PORT_C_LATCH_DIR: begin
				rd_val = s_r.dir;
			end
			`CPU_IDX_IRQ_EN_ONE: begin
				rd_val = s_r.irq_en;
			end
			`CPU_IDX_PWM_LIMIT: begin
				rd_val = s_r.pr2;
			end
			default: begin
				rd_hit = 1'b0;
			end
		endcase
		for (int u = 0; u < 2; u++) begin
			if (idx == VLO_IDX[u]) begin
				rd_val = s_r.vlo[u];
				rd_hit = 1'b1;
			end
			if (idx == VHI_IDX[u]) begin
				rd_val = s_r.vhi[u];
				rd_hit = 1'b1;
			end
			if (idx == CTL_IDX[u]) begin
				rd_val = s_r.ctl[u];
				rd_hit = 1'b1;
			end
		end
	end

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		logic trig;
		logic adc_go;
		logic [7:0] set_f;
		logic [7:0] set_b;
		logic [3:0] md;
		logic on_eq;
		trig = 1'b0;
		adc_go = 1'b0;
		set_f = 8'h00;
		set_b = 8'h00;
		md = 4'h0;
		on_eq = 1'b0;
		s_nxt = s_r;
		s_nxt.q = s_r.q + 2'b01;
		s_nxt.adc_start = 1'b0;

		if (setup) begin
			s_nxt.rdata = rd_val;
			s_nxt.err = !rd_hit;
		end

		if (icyc && s_r.event_timer_control[`CPU_T1_ON]) begin
			s_nxt.t1pre = s_r.t1pre + 3'b001;
		end
		if (icyc && s_r.pwm_timer_control[`CPU_T2_ON]) begin
			s_nxt.pre2 = s_r.pre2 + 4'h1;
		end

		for (int u = 0; u < 2; u++) begin
			md = s_r.ctl[u][3:0];

			// Compare fires once on the cycle equality first appears
			on_eq = (md[3:2] == cpu_pkg::CPU_CMP_PREFIX) && ({s_r.vhi[u], s_r.vlo[u]} == s_r.t1);
			s_nxt.eq[u] = on_eq;
			if (on_eq && !s_r.eq[u]) begin
				if (u == 0) begin
					set_f[`CPU_FLAG_UNIT_A] = 1'b1;
				end else begin
					set_b[`CPU_FLAG_UNIT_B] = 1'b1;
				end
				case (md)
					cpu_pkg::CPU_MODE_CMP_SET: begin
						s_nxt.outl[u] = 1'b1;
					end
					cpu_pkg::CPU_MODE_CMP_CLR: begin
						s_nxt.outl[u] = 1'b0;
					end
					cpu_pkg::CPU_MODE_CMP_TRIG: begin
						trig = 1'b1;
						if (u == 1) begin
							adc_go = adc_enabled;
						end
					end
					default: begin
						// Flag-only compare leaves the latch as it is
						s_nxt.outl[u] = s_r.outl[u];
					end
				endcase
			end

			if (md[3:2] == cpu_pkg::CPU_PWM_PREFIX) begin
				if (pmatch) begin
					// Buffer reloads only here, so a half-written duty never shows
					s_nxt.vhi[u] = s_r.vlo[u];
					s_nxt.lat2[u] = s_r.ctl[u][`CPU_CTL_DUTY_LSB +: 2];
					s_nxt.outl[u] = {s_r.vlo[u], s_r.ctl[u][`CPU_CTL_DUTY_LSB +: 2]} != 10'h000;
				end else if (frac_step && ({s_r.vhi[u], s_r.lat2[u]} == {s_r.pwm_base_timer, low2} + 10'h001)) begin
					// Falls as the count reaches the duty; a duty above the limit is never reached
					s_nxt.outl[u] = 1'b0;
				end
			end

			if (md == cpu_pkg::CPU_MODE_OFF) begin
				s_nxt.outl[u] = 1'b0;
				s_nxt.lat2[u] = 2'b00;
				s_nxt.eq[u] = 1'b0;
			end

			if (wr && idx == VLO_IDX[u]) begin
				s_nxt.vlo[u] = wd;
			end
			if (wr && idx == VHI_IDX[u] && md[3:2] != cpu_pkg::CPU_PWM_PREFIX) begin
				s_nxt.vhi[u] = wd;
			end
			if (wr && idx == CTL_IDX[u]) begin
				s_nxt.ctl[u] = wd & `CPU_CTL_MASK;
				if (wd[3:0] == cpu_pkg::CPU_MODE_OFF) begin
					s_nxt.outl[u] = 1'b0;
					s_nxt.lat2[u] = 2'b00;
					s_nxt.eq[u] = 1'b0;
				end
			end
		end

		// Event timer: a trigger clears it without counting as overflow
		if (trig) begin
			s_nxt.t1 = 16'h0000;
		end else if (t1tick) begin
			s_nxt.t1 = s_r.t1 + 16'h0001;
			if (s_r.t1 == 16'hffff) begin
				set_f[`CPU_FLAG_EVT_OVF] = 1'b1;
			end
		end

		// PWM base timer and its postscaler, which only paces the flag
		if (pmatch) begin
			s_nxt.pwm_base_timer = 8'h00;
			if (s_r.post == s_r.pwm_timer_control[`CPU_T2_POST_LSB +: 4]) begin
				s_nxt.post = 4'h0;
				set_f[`CPU_FLAG_PWM_TMR] = 1'b1;
			end else begin
				s_nxt.post = s_r.post + 4'h1;
			end
		end else if (t2tick) begin
			s_nxt.pwm_base_timer = s_r.pwm_base_timer + 8'h01;
		end

		// Software writes win over counting
		if (wr) begin
			case (idx)
				`CPU_IDX_CORE_IRQ: begin
					s_nxt.core_irq = wd;
				end
				`CPU_IDX_FLAGS_ONE: begin
					s_nxt.flags = wd;
				end
				`CPU_IDX_FLAGS_B: begin
					s_nxt.flags_b = wd & `CPU_FLAGS_B_MASK;
				end
				`CPU_IDX_TMR_LOW: begin
					s_nxt.t1[7:0] = wd;
				end
				`CPU_IDX_TMR_HIGH: begin
					s_nxt.t1[15:8] = wd;
				end
				`CPU_IDX_TMR_CTL: begin
					s_nxt.event_timer_control = wd & `CPU_EVENT_TIMER_CONTROL_MASK;
				end
				`CPU_IDX_PWM_TMR: begin
					s_nxt.pwm_base_timer = wd;
				end
				`CPU_IDX_PWM_TCTL: begin
					s_nxt.pwm_timer_control = wd & `CPU_PWM_TIMER_CONTROL_MASK;
				end
				`CPU_IDX_PORT_C_LATCH_DIR: begin
					s_nxt.dir = wd;
				end
				`CPU_IDX_IRQ_EN_ONE: begin
					s_nxt.irq_en = wd;
				end
				`CPU_IDX_PWM_LIMIT: begin
					s_nxt.pr2 = wd;
				end
				default: begin
					s_nxt.pr2 = s_nxt.pr2;
				end
			endcase
		end

		// Hardware set beats a software clear in the same cycle
		s_nxt.flags = s_nxt.flags | set_f;
		s_nxt.flags_b = s_nxt.flags_b | set_b;
		s_nxt.adc_start = adc_go;
	end

	// ****************************************
	// Registers
	// ****************************************
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			s_r <= '0;
			s_r.dir <= `CPU_RST_PORT_C_LATCH_DIR;
			s_r.pr2 <= `CPU_RST_PWM_LIMIT;
		end else begin
			s_r <= s_nxt;
		end
	end

	// ****************************************
	// Pins
	// ****************************************
	// Direction bit low means the pin drives; the port data latch is elsewhere
	assign unit_a_pin.out = s_r.outl[0];
	assign unit_a_pin.oe = !s_r.dir[`CPU_DIR_A];
	assign unit_b_pin.out = s_r.outl[1];
	assign unit_b_pin.oe = !s_r.dir[`CPU_DIR_B];
	assign adc_start = s_r.adc_start;

endmodule

`default_nettype wire

// [include/cpu_cfg.svh]
// Register indices, field positions and reset values of the compare/PWM unit.
`ifndef CPU_CFG_SVH
`define CPU_CFG_SVH

// ****************************************
// Register indices (byte address = 4 * index)
// ****************************************
`define CPU_IDX_CORE_IRQ 10'h00b
`define CPU_IDX_FLAGS_ONE 10'h00c
`define CPU_IDX_FLAGS_B 10'h00d
`define CPU_IDX_TMR_LOW 10'h00e
`define CPU_IDX_TMR_HIGH 10'h00f
`define CPU_IDX_TMR_CTL 10'h010
`define CPU_IDX_PWM_TMR 10'h011
`define CPU_IDX_PWM_TCTL 10'h012
`define CPU_IDX_A_VLO 10'h015
`define CPU_IDX_A_VHI 10'h016
`define CPU_IDX_A_CTL 10'h017
`define CPU_IDX_B_VLO 10'h01b
`define CPU_IDX_B_VHI 10'h01c
`define CPU_IDX_B_CTL 10'h01d
`define CPU_IDX_PORT_C_LATCH_DIR 10'h087
`define CPU_IDX_IRQ_EN_ONE 10'h08c
`define CPU_IDX_PWM_LIMIT 10'h092

// ****************************************
// Reset values
// ****************************************
`define CPU_RST_PORT_C_LATCH_DIR 8'hff
`define CPU_RST_PWM_LIMIT 8'hff

// ****************************************
// Field positions and writable masks
// ****************************************
`define CPU_FLAG_EVT_OVF 0
`define CPU_FLAG_PWM_TMR 1
`define CPU_FLAG_UNIT_A 2
`define CPU_FLAG_UNIT_B 0
`define CPU_T1_ON 0
`define CPU_T1_PS_LSB 4
`define CPU_T2_ON 2
`define CPU_T2_PS_LSB 0
`define CPU_T2_POST_LSB 3
`define CPU_CTL_DUTY_LSB 4
`define CPU_DIR_A 2
`define CPU_DIR_B 1
`define CPU_CTL_MASK 8'h3f
`define CPU_EVENT_TIMER_CONTROL_MASK 8'h3f
`define CPU_PWM_TIMER_CONTROL_MASK 8'h7f
`define CPU_FLAGS_B_MASK 8'h01

`endif

// [include/cpu_pkg.sv]
// Types shared by the compare/PWM unit and its bench.
package cpu_pkg;

	typedef enum logic [3:0] {
		CPU_MODE_OFF = 4'h0,
		CPU_MODE_CMP_SET = 4'h8,
		CPU_MODE_CMP_CLR = 4'h9,
		CPU_MODE_CMP_FLAG = 4'ha,
		CPU_MODE_CMP_TRIG = 4'hb
	} cpu_mode_type;

	localparam logic [1:0] CPU_CMP_PREFIX = 2'b10;
	localparam logic [1:0] CPU_PWM_PREFIX = 2'b11;

	typedef struct packed {
		logic out;
		logic oe;
	} cpu_pin_type;

	typedef struct packed {
		logic [1:0] q;
		logic [15:0] t1;
		logic [7:0] event_timer_control;
		logic [2:0] t1pre;
		logic [7:0] pwm_base_timer;
		logic [7:0] pwm_timer_control;
		logic [7:0] pr2;
		logic [3:0] pre2;
		logic [3:0] post;
		logic [1:0][7:0] vlo;
		logic [1:0][7:0] vhi;
		logic [1:0][7:0] ctl;
		logic [1:0][1:0] lat2;
		logic [1:0] outl;
		logic [1:0] eq;
		logic [7:0] flags;
		logic [7:0] flags_b;
		logic [7:0] irq_en;
		logic [7:0] core_irq;
		logic [7:0] dir;
		logic [7:0] rdata;
		logic err;
		logic adc_start;
	} cpu_state_type;

endpackage

// [tb/cpu_load.sv]
// Load model on a unit pin: measures pulse high time and period.
`timescale 1ns/1ns
`default_nettype none
module cpu_load (
	input wire logic clk,
	input wire cpu_pkg::cpu_pin_type pin,
	output int hi_len,
	output int per_len,
	output int rises
);
	logic lvl;
	logic lvl_r = 1'b0;
	int hi_cnt = 0;
	int per_cnt = 0;
	// Pull-down: an undriven pin reads low, never the last driven value
	assign lvl = pin.oe ? pin.out : 1'b0;
	initial begin
		hi_len = 0;
		per_len = 0;
		rises = 0;
	end
	always @(posedge clk) begin
		lvl_r <= lvl;
		per_cnt <= (lvl && !lvl_r) ? 1 : per_cnt + 1;
		hi_cnt <= lvl ? hi_cnt + 1 : 0;
		if (lvl && !lvl_r) begin
			per_len <= per_cnt;
			rises <= rises + 1;
		end
		if (!lvl && lvl_r) begin
			hi_len <= hi_cnt;
		end
	end
endmodule
`default_nettype wire

// [tb/cpu_top_sva.sv]
// Port checker of the compare/PWM unit pair.
`timescale 1ns/1ns
`default_nettype none
`include "cpu_cfg.svh"
module cpu_chk (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [11:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	input wire logic pready,
	input wire logic [31:0] prdata,
	input wire logic pslverr,
	input wire logic adc_enabled,
	input wire cpu_pkg::cpu_pin_type unit_a_pin,
	input wire cpu_pkg::cpu_pin_type unit_b_pin,
	input wire logic adc_start
);
	// ****
	// Mode shadow taken from bus writes
	// ****
	logic [3:0] mode_a_r;
	logic [3:0] mode_b_r;
	logic wr_hit;
	assign wr_hit = psel && penable && pwrite;
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			mode_a_r <= 4'h0;
			mode_b_r <= 4'h0;
		end else if (wr_hit && paddr[11:2] == `CPU_IDX_A_CTL) begin
			mode_a_r <= pwdata[3:0];
		end else if (wr_hit && paddr[11:2] == `CPU_IDX_B_CTL) begin
			mode_b_r <= pwdata[3:0];
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	sequence s_zero_a;
		wr_hit && paddr[11:2] == `CPU_IDX_A_CTL && pwdata[7:0] == 8'h00;
	endsequence
	sequence s_held_a(m);
		mode_a_r == m && $past(mode_a_r) == m;
	endsequence
	AST_ZERO_A: assert property (s_zero_a |=> !unit_a_pin.out) else $error("pin a high after zero control");
	AST_OFF_A: assert property (mode_a_r == 4'h0 |-> !unit_a_pin.out) else $error("pin a high while off");
	AST_OFF_B: assert property (mode_b_r == 4'h0 |-> !unit_b_pin.out) else $error("pin b high while off");
	AST_SET_A: assert property (s_held_a(4'h8) |-> !$fell(unit_a_pin.out)) else $error("pin a fell in set mode");
	AST_CLR_A: assert property (s_held_a(4'h9) |-> !$rose(unit_a_pin.out)) else $error("pin a rose in clear mode");
	AST_FLAG_A: assert property (s_held_a(4'ha) |-> $stable(unit_a_pin.out)) else $error("pin a moved in flag mode");
	AST_ADC_CAUSE: assert property (adc_start |-> mode_b_r == 4'hb && $past(adc_enabled)) else $error("stray conversion start");
	AST_ADC_PULSE: assert property (adc_start |=> !adc_start) else $error("conversion start too long");
endmodule
bind cpu_top cpu_chk cpu_chk_i (.clk(clk), .rst_n(rst_n), .paddr(paddr), .psel(psel), .penable(penable),
	.pwrite(pwrite), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
	.adc_enabled(adc_enabled), .unit_a_pin(unit_a_pin), .unit_b_pin(unit_b_pin), .adc_start(adc_start));
`default_nettype wire

// [tb/test_compare_pwm_unit.sv]
// Self-checking bench of the compare/PWM unit pair.
`timescale 1ns/1ns
`default_nettype none
`include "cpu_cfg.svh"
module test_compare_pwm_unit;
	logic clk, rst_n, psel, penable, pwrite, pready, pslverr, adc_enabled, adc_start, sl;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rv;
	cpu_pkg::cpu_pin_type pin_a, pin_b;
	int hi_len, per_len, rises, errors, compares, seed, adc_seen, s, r0;
	logic [9:0] duty, old;
	cpu_top cpu_top_i (.clk(clk), .rst_n(rst_n), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
		.adc_enabled(adc_enabled), .unit_a_pin(pin_a), .unit_b_pin(pin_b), .adc_start(adc_start));
	cpu_load cpu_load_i (.clk(clk), .pin(pin_a), .hi_len(hi_len), .per_len(per_len), .rises(rises));
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	always @(posedge clk) begin
		if (adc_start === 1'b1) adc_seen <= adc_seen + 1;
	end
	// ****
	// Bus and check tasks
	// ****
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e) begin
			errors++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic xfer(input logic [9:0] i, input logic w, input logic [7:0] d);
		paddr <= {i, 2'b00};
		pwrite <= w;
		pwdata <= {24'h00_0000, d};
		psel <= 1'b1;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1) @(posedge clk);
		rv = prdata;
		sl = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask
	task automatic wr(input logic [9:0] i, input logic [7:0] d);
		xfer(i, 1'b1, d);
	endtask
	task automatic rd(input logic [9:0] i, input logic [7:0] e);
		xfer(i, 1'b0, 8'h00);
		chk($sformatf("reg %h", i), {24'h00_0000, e}, rv);
	endtask
	task automatic poll(input logic [9:0] i, input logic [7:0] m);
		do xfer(i, 1'b0, 8'h00); while ((rv[7:0] & m) == 8'h00);
	endtask
	task automatic wait_rise(input int k);
		int r;
		r = rises + k;
		while (rises < r) @(posedge clk);
	endtask
	task automatic test_done;
		if (errors == 0 && compares > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	initial begin
		#400000;
		errors++;
		test_done;
	end
	// ****
	// Main sequence
	// ****
	initial begin
		{seed, errors, compares, adc_seen} = {32'd51002, 96'd0};
		{rst_n, psel, penable, pwrite, adc_enabled, paddr, pwdata} = '0;
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		chk("reset pins", 32'h0000_0000, {28'h000_0000, pin_a, pin_b});
		rd(`CPU_IDX_PORT_C_LATCH_DIR, 8'hff);
		rd(`CPU_IDX_PWM_LIMIT, 8'hff);
		rd(`CPU_IDX_A_CTL, 8'h00);
		xfer(10'h3ff, 1'b0, 8'h00);
		chk("slverr", 32'h0000_0001, {31'h0000_0000, sl});
		chk("unmapped data", 32'h0000_0000, rv);
		wr(`CPU_IDX_A_CTL, 8'hf0);
		rd(`CPU_IDX_A_CTL, 8'h30);
		wr(`CPU_IDX_PORT_C_LATCH_DIR, 8'hf9);
		chk("pins", 32'h0000_0005, {28'h000_0000, pin_a, pin_b});
		wr(`CPU_IDX_A_VLO, 8'h10);
		wr(`CPU_IDX_A_CTL, 8'h08);
		wr(`CPU_IDX_TMR_CTL, 8'h01);
		while (pin_a.out !== 1'b1) @(posedge clk);
		rd(`CPU_IDX_FLAGS_ONE, 8'h04);
		wr(`CPU_IDX_FLAGS_ONE, 8'h00);
		wr(`CPU_IDX_A_CTL, 8'h09);
		wr(`CPU_IDX_TMR_LOW, 8'h00);
		while (pin_a.out !== 1'b0) @(posedge clk);
		rd(`CPU_IDX_FLAGS_ONE, 8'h04);
		wr(`CPU_IDX_FLAGS_ONE, 8'h00);
		wr(`CPU_IDX_A_CTL, 8'h0a);
		wr(`CPU_IDX_TMR_LOW, 8'h00);
		poll(`CPU_IDX_FLAGS_ONE, 8'h04);
		chk("flag mode pin", 32'h0000_0000, {31'h0000_0000, pin_a.out});
		wr(`CPU_IDX_A_CTL, 8'h0b);
		wr(`CPU_IDX_FLAGS_ONE, 8'h00);
		wr(`CPU_IDX_TMR_LOW, 8'h00);
		poll(`CPU_IDX_FLAGS_ONE, 8'h04);
		xfer(`CPU_IDX_TMR_LOW, 1'b0, 8'h00);
		chk("timer a", 32'h0000_0001, {31'h0000_0000, rv[7:0] < 8'h08});
		wr(`CPU_IDX_A_CTL, 8'h00);
		adc_enabled <= 1'b1;
		wr(`CPU_IDX_FLAGS_ONE, 8'h00);
		wr(`CPU_IDX_B_VLO, 8'h10);
		wr(`CPU_IDX_B_CTL, 8'h0b);
		poll(`CPU_IDX_FLAGS_B, 8'h01);
		xfer(`CPU_IDX_TMR_LOW, 1'b0, 8'h00);
		chk("timer b", 32'h0000_0001, {31'h0000_0000, rv[7:0] < 8'h08});
		rd(`CPU_IDX_FLAGS_ONE, 8'h00);
		chk("adc", 32'h0000_0001, {31'h0000_0000, adc_seen > 0});
		wr(`CPU_IDX_B_CTL, 8'h00);
		wr(`CPU_IDX_TMR_CTL, 8'h00);
		for (int p = 0; p < 3; p++) begin
			s = (p == 0) ? 1 : (p == 1) ? 4 : 16;
			duty = 10'($unsigned($random(seed)) % 15 + 1);
			wr(`CPU_IDX_A_CTL, 8'h00);
			wr(`CPU_IDX_PWM_LIMIT, 8'h03);
			wr(`CPU_IDX_A_VLO, {6'h00, duty[3:2]});
			wr(`CPU_IDX_PWM_TCTL, {1'b0, 4'($random(seed)), 1'b1, 2'(p)});
			wr(`CPU_IDX_A_CTL, {2'b00, duty[1:0], 4'hc});
			wait_rise(3);
			chk("period", 32'(16 * s), per_len);
			chk("high", 32'(duty * s), hi_len);
			rd(`CPU_IDX_A_VHI, {6'h00, duty[3:2]});
			wr(`CPU_IDX_A_VHI, 8'hff);
			rd(`CPU_IDX_A_VHI, {6'h00, duty[3:2]});
		end
		old = duty;
		duty = (duty % 15) + 1;
		wr(`CPU_IDX_A_VLO, {6'h00, duty[3:2]});
		wr(`CPU_IDX_A_CTL, {2'b00, duty[1:0], 4'hc});
		wait_rise(1);
		chk("old high", 32'(old * s), hi_len);
		wait_rise(1);
		chk("new high", 32'(duty * s), hi_len);
		wr(`CPU_IDX_A_VLO, 8'h00);
		wr(`CPU_IDX_A_CTL, 8'h0c);
		r0 = rises;
		repeat (48 * s) @(posedge clk);
		chk("zero duty", 32'(r0), rises);
		wr(`CPU_IDX_A_VLO, 8'hff);
		wr(`CPU_IDX_A_CTL, 8'h3c);
		repeat (48 * s) @(posedge clk);
		chk("long duty", 32'(r0 + 1), rises);
		chk("long pin", 32'h0000_0001, {31'h0000_0000, pin_a.out});
		wr(`CPU_IDX_A_CTL, 8'h00);
		chk("off pin", 32'h0000_0000, {31'h0000_0000, pin_a.out});
		test_done;
	end
endmodule
`default_nettype wire
